// ---- shared/btn_cfg_pkg.sv ----
// Constants and carrier types for the button algorithm configuration registers
package btn_cfg_pkg;
  localparam int          NumCh          = 4;
  localparam int          ValueWidth     = 16;
  // Register offsets
  localparam logic [7:0]  OffDivider     = 8'h17;
  localparam logic [7:0]  OffRelease     = 8'h18;
  localparam logic [7:0]  OffTwist       = 8'h19;
  localparam logic [7:0]  OffGroup       = 8'h1a;
  localparam logic [7:0]  OffPolarity    = 8'h1c;
  // Reset values
  localparam logic [7:0]  RstDivider     = 8'h03;
  localparam logic [7:0]  RstRelease     = 8'h08;
  localparam logic [7:0]  RstTwist       = 8'h00;
  localparam logic [7:0]  RstGroup       = 8'h00;
  localparam logic [7:0]  RstPolarity    = 8'h0f;
  // Field positions
  localparam int          DividerLsb     = 0;
  localparam int          DividerBits    = 3;
  localparam int          ReleaseLsb     = 0;
  localparam int          ReleaseBits    = 4;
  localparam int          TwistLsb       = 0;
  localparam int          TwistBits      = 3;
  localparam int          CommonLsb      = 4;
  localparam int          DeformLsb      = 0;
  localparam int          OutPolLsb      = 4;
  localparam int          DataPolLsb     = 0;
  // Threshold scale: both hysteresis and twist threshold are field times four
  localparam int          ThreshShift    = 2;
  localparam int          CycleBits      = 5;
  localparam int          WindowBits     = CycleBits + 7;

  typedef struct packed {
    logic [7:0] addr;
    logic       wrEn;
    logic       rdEn;
    logic [7:0] wrData;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] divider;
    logic [7:0] releaseMargin;
    logic [7:0] twistGuard;
    logic [7:0] groupSel;
    logic [7:0] polarity;
  } cfg_regs_t;
endpackage : btn_cfg_pkg

// ---- logic/button_algorithm_config_regs.sv ----
// Button algorithm configuration registers with their direct effects on the button path
//
// Contract
// - Divider bits 2-0 with cycles set window
// - Release margin resets 8h; hysteresis four times
// - Twist guard zero disables anti-twist check
// - Nonzero guard: any value below minus 4x cancels
// - Group bits 7-4 select common membership ch3-0
// - Group bits 3-0 select deform membership ch3-0
// - Twist guard at 19h resets to 00h
// - Polarity register at 1Ch resets to 0Fh
// - Polarity bits 7-4: output pin level sense
// - Polarity bits 3-0: processed value direction
`timescale 1ns/1ps
module button_algorithm_config_regs
  import btn_cfg_pkg::*;
#(
  parameter int ValueW = ValueWidth
) (
  input  wire logic                          clock,
  input  wire logic                          nrst,
  input  wire reg_req_t                      regReq,
  output logic      [7:0]                    regRdData,
  input  wire logic [NumCh-1:0][CycleBits-1:0] sensorCycleCount,
  input  wire logic [NumCh-1:0][ValueW-1:0]  processedButtonValue,
  input  wire logic [NumCh-1:0]              buttonDetect,
  output logic      [NumCh-1:0][WindowBits-1:0] samplingWindow,
  output logic      [ReleaseBits+ThreshShift-1:0] releaseHysteresis,
  output logic      [NumCh-1:0]              commonGroupMember,
  output logic      [NumCh-1:0]              deformGroupMember,
  output logic      [NumCh-1:0]              processedValueDirection,
  output logic                               twistCancel,
  output logic      [NumCh-1:0]              buttonOutputPin
);

  // Elaboration checks: every field must sit inside its byte and the window must hold
  // the largest cycle count shifted by the largest divider
  if (ValueW < TwistBits + ThreshShift + 2) begin : g_chk_value_width
    $error("ValueW too narrow for the twist threshold");
  end
  if (CycleBits + (1 << DividerBits) - 1 > WindowBits) begin : g_chk_window_width
    $error("WindowBits too narrow for the sampling window");
  end
  if (DividerLsb + DividerBits > 8) begin : g_chk_divider_field
    $error("Divider field outside its register");
  end
  if (ReleaseLsb + ReleaseBits > 8) begin : g_chk_release_field
    $error("Release field outside its register");
  end
  if (TwistLsb + TwistBits > 8) begin : g_chk_twist_field
    $error("Twist field outside its register");
  end
  if (CommonLsb + NumCh > 8 || DeformLsb + NumCh > CommonLsb) begin : g_chk_group_fields
    $error("Group fields do not fit their register");
  end
  if (OutPolLsb + NumCh > 8 || DataPolLsb + NumCh > OutPolLsb) begin : g_chk_polarity_fields
    $error("Polarity fields do not fit their register");
  end

  typedef struct packed {
    logic [7:0]                           rdData;
    logic [NumCh-1:0][WindowBits-1:0]     window;
    logic [ReleaseBits+ThreshShift-1:0]   hysteresis;
    logic                                 cancel;
    logic [NumCh-1:0]                     pins;
  } state_t;

  state_t state_q;
  state_t state_d;

  // Register decode and storage
  logic                   wrDivider;
  logic                   wrRelease;
  logic                   wrTwist;
  logic                   wrGroup;
  logic                   wrPolarity;
  logic [7:0]             dividerReg;
  logic [7:0]             releaseReg;
  logic [7:0]             twistReg;
  logic [7:0]             groupReg;
  logic [7:0]             polarityReg;
  cfg_regs_t              regs;
  logic [7:0]             rdMux;

  // Field views of the stored registers
  logic [DividerBits-1:0] dividerField;
  logic [ReleaseBits-1:0] releaseField;
  logic [TwistBits-1:0]   twistField;
  logic [NumCh-1:0]       outPol;
  logic                   twistEnabled;

  // Button path
  logic signed [ValueW-1:0]              twistLimit;
  wire logic [NumCh-1:0]                 belowLimit;
  wire logic [NumCh-1:0][WindowBits-1:0] windowNext;
  wire logic [NumCh-1:0]                 pinNext;
  logic                                  cancelNext;

  // Writes are honoured only at the five decoded offsets; any other offset is ignored
  assign wrDivider  = regReq.wrEn && (regReq.addr == OffDivider);
  assign wrRelease  = regReq.wrEn && (regReq.addr == OffRelease);
  assign wrTwist    = regReq.wrEn && (regReq.addr == OffTwist);
  assign wrGroup    = regReq.wrEn && (regReq.addr == OffGroup);
  assign wrPolarity = regReq.wrEn && (regReq.addr == OffPolarity);

  cfg_byte_reg #(
    .ResetValue (RstDivider)
  ) dividerStore (
    .clock  (clock),
    .nrst   (nrst),
    .wrHit  (wrDivider),
    .wrData (regReq.wrData),
    .value  (dividerReg)
  );

  cfg_byte_reg #(
    .ResetValue (RstRelease)
  ) releaseStore (
    .clock  (clock),
    .nrst   (nrst),
    .wrHit  (wrRelease),
    .wrData (regReq.wrData),
    .value  (releaseReg)
  );

  cfg_byte_reg #(
    .ResetValue (RstTwist)
  ) twistStore (
    .clock  (clock),
    .nrst   (nrst),
    .wrHit  (wrTwist),
    .wrData (regReq.wrData),
    .value  (twistReg)
  );

  cfg_byte_reg #(
    .ResetValue (RstGroup)
  ) groupStore (
    .clock  (clock),
    .nrst   (nrst),
    .wrHit  (wrGroup),
    .wrData (regReq.wrData),
    .value  (groupReg)
  );

  cfg_byte_reg #(
    .ResetValue (RstPolarity)
  ) polarityStore (
    .clock  (clock),
    .nrst   (nrst),
    .wrHit  (wrPolarity),
    .wrData (regReq.wrData),
    .value  (polarityReg)
  );

  assign regs = '{
    divider:       dividerReg,
    releaseMargin: releaseReg,
    twistGuard:    twistReg,
    groupSel:      groupReg,
    polarity:      polarityReg
  };

  assign dividerField = regs.divider[DividerLsb +: DividerBits];
  assign releaseField = regs.releaseMargin[ReleaseLsb +: ReleaseBits];
  assign twistField   = regs.twistGuard[TwistLsb +: TwistBits];
  assign outPol       = regs.polarity[OutPolLsb +: NumCh];
  assign twistEnabled = (twistField != '0);

  // Read data comes from the stored bytes before any write of the same cycle
  function automatic logic [7:0] readBack(input cfg_regs_t r, input logic [7:0] addr);
    logic [7:0] value;
    value = 8'h00;
    case (addr)
      OffDivider:  value = r.divider;
      OffRelease:  value = r.releaseMargin;
      OffTwist:    value = r.twistGuard;
      OffGroup:    value = r.groupSel;
      OffPolarity: value = r.polarity;
      default:     value = 8'h00;
    endcase
    return value;
  endfunction : readBack

  assign rdMux = readBack(regs, regReq.addr);

  // The limit is the negated field times four; a zero field is handled by the enable
  assign twistLimit = -$signed(ValueW'({twistField, {ThreshShift{1'b0}}}));
  // A zero field gives limit zero, but the check must be fully off then
  assign cancelNext = twistEnabled && (|belowLimit);

  for (genvar ch = 0; ch < NumCh; ch++) begin : g_channel
    button_channel_path #(
      .ValueW (ValueW)
    ) path (
      .cycleCount   (sensorCycleCount[ch]),
      .dividerField (dividerField),
      .value        (processedButtonValue[ch]),
      .twistLimit   (twistLimit),
      .press        (buttonDetect[ch]),
      .cancel       (cancelNext),
      .pinPolarity  (outPol[ch]),
      .windowNext   (windowNext[ch]),
      .belowLimit   (belowLimit[ch]),
      .pinNext      (pinNext[ch])
    );
  end

  always_comb begin
    state_d = state_q;
    if (regReq.rdEn) begin
      state_d.rdData = rdMux;
    end
    state_d.window     = windowNext;
    state_d.hysteresis = {releaseField, {ThreshShift{1'b0}}};
    state_d.cancel     = cancelNext;
    state_d.pins       = pinNext;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q.rdData     <= 8'h00;
      state_q.window     <= '0;
      state_q.hysteresis <= '0;
      state_q.cancel     <= 1'b0;
      // Default polarity is active low, so idle pins sit high
      state_q.pins       <= '1;
    end else begin
      state_q <= state_d;
    end
  end

  assign regRdData               = state_q.rdData;
  assign samplingWindow          = state_q.window;
  assign releaseHysteresis       = state_q.hysteresis;
  assign commonGroupMember       = regs.groupSel[CommonLsb +: NumCh];
  assign deformGroupMember       = regs.groupSel[DeformLsb +: NumCh];
  assign processedValueDirection = regs.polarity[DataPolLsb +: NumCh];
  assign twistCancel             = state_q.cancel;
  assign buttonOutputPin         = state_q.pins;

endmodule : button_algorithm_config_regs

// One channel's share of the button path: window length, twist compare and pin level
module button_channel_path
  import btn_cfg_pkg::*;
#(
  parameter int ValueW = ValueWidth
) (
  input  wire logic        [CycleBits-1:0]   cycleCount,
  input  wire logic        [DividerBits-1:0] dividerField,
  input  wire logic signed [ValueW-1:0]      value,
  input  wire logic signed [ValueW-1:0]      twistLimit,
  input  wire logic                          press,
  input  wire logic                          cancel,
  input  wire logic                          pinPolarity,
  output logic             [WindowBits-1:0]  windowNext,
  output logic                               belowLimit,
  output logic                               pinNext
);

  logic validPress;

  // Window grows by powers of two of the divider field
  assign windowNext = WindowBits'({{(WindowBits-CycleBits){1'b0}}, cycleCount}
                                  << dividerField);
  assign belowLimit = value < twistLimit;
  // Cancel masks every channel in the same cycle
  assign validPress = press && !cancel;
  // Polarity 0 gives an active-low pin
  assign pinNext = pinPolarity ? validPress : !validPress;

endmodule : button_channel_path

// One byte-wide configuration register with its own write strobe
module cfg_byte_reg
  import btn_cfg_pkg::*;
#(
  parameter logic [7:0] ResetValue = 8'h00
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       wrHit,
  input  wire logic [7:0] wrData,
  output logic      [7:0] value
);

  typedef struct packed {
    logic [7:0] value;
  } byte_state_t;

  byte_state_t state_q;
  byte_state_t state_d;

  always_comb begin
    state_d = state_q;
    // Reserved bits are kept as written so a read returns what the host stored
    if (wrHit) begin
      state_d.value = wrData;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q.value <= ResetValue;
    end else begin
      state_q <= state_d;
    end
  end

  assign value = state_q.value;

endmodule : cfg_byte_reg

// ---- test/btn_cfg_chk_asserts.sv ----
// Checker for the button configuration register ports
`timescale 1ns/1ps
module btn_cfg_chk import btn_cfg_pkg::*; (
  input wire logic                           clock,
  input wire logic                           nrst,
  input wire reg_req_t                       regReq,
  input wire logic [7:0]                     regRdData,
  input wire logic [NumCh-1:0][CycleBits-1:0]  sensorCycleCount,
  input wire logic [NumCh-1:0][15:0]         processedButtonValue,
  input wire logic [NumCh-1:0][WindowBits-1:0] samplingWindow,
  input wire logic [5:0]                     releaseHysteresis,
  input wire logic [3:0]                     commonGroupMember,
  input wire logic [3:0]                     deformGroupMember,
  input wire logic [3:0]                     processedValueDirection,
  input wire logic                           twistCancel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  function automatic logic wa(logic [7:0] a); return regReq.wrEn && regReq.addr == a; endfunction
  AST_WINDOW: assert property (wa(OffDivider) |=> ##1 samplingWindow[0] ==
    WindowBits'($past(sensorCycleCount[0])) << $past(regReq.wrData[2:0], 2)) else $error("window");
  AST_RELEASE: assert property (wa(OffRelease) |=> ##1
    releaseHysteresis == {$past(regReq.wrData[3:0], 2), 2'b00}) else $error("hysteresis");
  AST_TWIST_OFF: assert property (wa(OffTwist) && regReq.wrData[2:0] == 3'h0
    |=> ##1 !twistCancel) else $error("twist off");
  AST_TWIST_ON: assert property (wa(OffTwist) && regReq.wrData[2:0] != 3'h0 ##1
    int'($signed(processedButtonValue[2])) < -4 * int'($past(regReq.wrData[2:0]))
    |=> twistCancel) else $error("twist on");
  AST_GROUP: assert property (wa(OffGroup) |=>
    {commonGroupMember, deformGroupMember} == $past(regReq.wrData)) else $error("group");
  AST_DIR: assert property (wa(OffPolarity) |=>
    processedValueDirection == $past(regReq.wrData[3:0])) else $error("direction");
  AST_TWIST_RB: assert property (wa(OffTwist) ##2 regReq.rdEn && regReq.addr == OffTwist
    |=> regRdData == $past(regReq.wrData, 3)) else $error("twist readback");
  AST_POL_RB: assert property (wa(OffPolarity) ##2 regReq.rdEn && regReq.addr == OffPolarity
    |=> regRdData == $past(regReq.wrData, 3)) else $error("polarity readback");
  cover property (twistCancel);
  cover property (wa(OffPolarity));
  cover property (regReq.rdEn);
endmodule : btn_cfg_chk

// ---- test/host_model.sv ----
// Host model issuing single-byte register transfers
`timescale 1ns/1ps
module host_model import btn_cfg_pkg::*; (
  input  wire logic       clock,
  output reg_req_t        regReq,
  input  wire logic [7:0] regRdData
);
  initial regReq = '0;
  // Callers pass reserved bits as zero
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    #1 regReq = '{a, 1'b1, 1'b0, d};
    @(posedge clock);
    #1 regReq.wrEn = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1 regReq = '{a, 1'b0, 1'b1, regReq.wrData};
    @(posedge clock);
    #1 regReq.rdEn = 1'b0;
    d = regRdData;
  endtask : rd
endmodule : host_model

// ---- test/tb.sv ----
// Self-checking bench for the button configuration registers
`timescale 1ns/1ps
module tb import btn_cfg_pkg::*; ;
  logic             clock = 0, nrst = 0, twistCancel;
  reg_req_t         regReq;
  logic [7:0]       regRdData, rdv;
  logic [3:0][4:0]  sensorCycleCount = {5'd31, 5'd4, 5'd9, 5'd1};
  logic [3:0][15:0] processedButtonValue = '0;
  logic [3:0]       buttonDetect = 4'h0, commonGroupMember, deformGroupMember;
  logic [3:0]       processedValueDirection, buttonOutputPin;
  logic [3:0][11:0] samplingWindow;
  logic [5:0]       releaseHysteresis;
  int               nMismatch = 0, nTests = 0;
  button_algorithm_config_regs dut (.*);
  host_model host (.*);
  initial forever #20 clock = ~clock;
  task automatic tick(); repeat (2) @(posedge clock); #1; endtask : tick
  task automatic chk(logic [63:0] got, exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic stopTest();
    if (nMismatch == 0 && nTests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stopTest
  task automatic tReset();
    logic [7:0] a[5] = '{OffDivider, OffRelease, OffTwist, OffGroup, OffPolarity};
    logic [7:0] e[5] = '{RstDivider, 8'h08, 8'h00, 8'h00, 8'h0f};
    foreach (a[i]) begin
      host.rd(a[i], rdv);
      chk(rdv, e[i]);
    end
    host.rd(8'h1b, rdv);
    chk(rdv, 8'h00);
    chk({releaseHysteresis, processedValueDirection, buttonOutputPin}, 14'h20ff);
  endtask : tReset
  task automatic tWindow();
    host.wr(OffDivider, 8'h07);
    tick();
    chk(samplingWindow, {12'hf80, 12'h200, 12'h480, 12'h080});
    host.wr(OffDivider, 8'h00);
    tick();
    chk(samplingWindow, {12'h01f, 12'h004, 12'h009, 12'h001});
    host.wr(OffRelease, 8'h0f);
    host.wr(OffGroup, 8'ha5);
    tick();
    chk({releaseHysteresis, commonGroupMember, deformGroupMember}, 14'h3ca5);
  endtask : tWindow
  task automatic tPolTwist();
    buttonDetect = 4'b0110;
    processedButtonValue[2] = -16'sd5;
    host.wr(OffPolarity, 8'ha3);
    tick();
    chk({twistCancel, buttonOutputPin, processedValueDirection}, 9'h033);
    host.rd(OffPolarity, rdv);
    chk(rdv, 8'ha3);
    host.wr(OffTwist, 8'h01);
    tick();
    chk({twistCancel, buttonOutputPin}, 5'h15);
    host.rd(OffTwist, rdv);
    chk(rdv, 8'h01);
    processedButtonValue[2] = -16'sd4;
    tick();
    chk(twistCancel, 1'b0);
    processedButtonValue[2] = -16'sd5;
    host.wr(OffTwist, 8'h00);
    tick();
    chk(twistCancel, 1'b0);
  endtask : tPolTwist
  initial begin
    repeat (10) @(posedge clock);
    #1 nrst = 1;
    tReset();
    tWindow();
    tPolTwist();
    stopTest();
  end
  initial begin
    repeat (3000) @(posedge clock);
    nMismatch++;
    stopTest();
  end
endmodule : tb
bind button_algorithm_config_regs btn_cfg_chk chk (.*);
